// ---- rtl/dmsep_pkg.sv ----
/*
 holds the constants, the controller state type and the behaviour list
 of the dual-mode serial memory port.
 assumes a 10 MHz system clock; no other file defines these names except WR_CYC, also a parameter of the port.
*/
// Contract
// - after power-up, transmit-only mode clocks one data bit per transmit clock.
// - a falling bus clock switches to two-wire slave mode.
// - slave mode is left only by a power cycle.
// - no valid data until nine transmit clocks of initialization.
// - data line high in first eight clocks starts at 7FH, else 00H.
// - data line released on the ninth initialization clock.
// - bytes go out MSB first, ninth slot released.
// - array streams continuously, wrapping 7FH to 00H.
// - in slave mode transmit clock is only a write-enable level.
// - transmit clock low in slave mode blocks all programming.
// - a started programming cycle completes whatever the transmit clock does.
// - start and stop decoded while bus clock high; idle until start.
// - upper address nibble matches device code; next three ignored; LSB read.
// - acknowledge matching address, and every byte of a write.
// - reads release after each byte; master ack continues, no ack ends.
// - word address to pointer, data to buffer; program at stop, deaf meanwhile.
// - up to 16 bytes per write; only low address bits increment.
// - more than sixteen bytes wrap and overwrite buffered bytes.
// - no acknowledge to polls while programming; ack once finished.
// - address counter holds last accessed plus one, wrapping 127 to 0.
// - sequential read gives one byte per master ack, wrapping at end.
// - write cycle lasts at most 5 ms; bus interface disabled.
package dmsep_pkg;
   // timing
   localparam int unsigned CLK_HZ   = 10_000_000;
   localparam int unsigned T_WR_MS  = 5;
   localparam int unsigned WR_CYC   = T_WR_MS * (CLK_HZ / 1000);
   // geometry
   localparam int unsigned ADDR_W   = 7;
   localparam int unsigned PAGE_W   = 4;
   // transmit-only sequencing
   localparam logic [6:0] TX_START_HI = 7'h7f;
   localparam logic [6:0] TX_START_LO = 7'h00;
   localparam logic [3:0] INIT_DONE   = 4'h9;
   localparam logic [3:0] INIT_LAST   = 4'h8;
   localparam logic [3:0] INIT_PICK   = 4'h7;
   localparam logic [3:0] SLOT_ACK    = 4'h8;
   localparam logic [3:0] SLOT_NEXT   = 4'h6;
   // programming walk over the page buffer
   localparam logic [4:0] STEP_LAST   = 5'h10;
   localparam logic [4:0] STEP_END    = 5'h11;
   // device-type code; value is arbitrary
   localparam logic [3:0] DEV_CODE_DEF = 4'h6;

   typedef enum logic [3:0] {
      IDLE, ADDR, ADDR_ACK, WORD, WORD_ACK,
      WDATA, WDATA_ACK, RDATA, RDATA_ACK, PROG
   } dmsep_st_e;
endpackage

// ---- rtl/dmsep_sync.sv ----
/*
 two flip-flop level synchroniser, one per bit.
 assumes each bit is a slow level relative to clk.
*/
`timescale 1ns/1ps
module dmsep_sync #(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // dmsep_sync

// ---- rtl/dmsep_mem.sv ----
/*
 byte array with one write port and two registered read ports,
 the second read port on its own clock.
 assumes the array is not written while port b reads the same word.
*/
`timescale 1ns/1ps
module dmsep_mem #(
   parameter int unsigned DW = 8,
   parameter int unsigned AW = 7
) (
   input  wire logic          clk_a,
   input  wire logic          we,
   input  wire logic [AW-1:0] wa,
   input  wire logic [DW-1:0] wd,
   input  wire logic [AW-1:0] ra,
   output logic      [DW-1:0] rd_a,
   input  wire logic          clk_b,
   input  wire logic [AW-1:0] rb,
   output logic      [DW-1:0] rd_b
);
   logic [DW-1:0] cells [2**AW];

   // write and read on the system clock
   always_ff @(posedge clk_a) begin
      if (we) begin
         cells[wa] <= wd;
      end
      rd_a <= cells[ra];
   end

   // read on the second clock
   always_ff @(posedge clk_b) begin
      rd_b <= cells[rb];
   end
endmodule // dmsep_mem

// ---- rtl/dmsep_port.sv ----
/*
 serial port of a 128-byte dual-mode memory: transmit-only streaming on
 the transmit clock, then a two-wire slave with page buffer and
 self-timed write cycle on the system clock.
 assumes an open-drain data line resolved outside, RST_B at power-up only.
*/
`timescale 1ns/1ps
module dmsep_port #(
   parameter logic [3:0]  DEV_CODE = dmsep_pkg::DEV_CODE_DEF,
   parameter int unsigned WR_CYC   = dmsep_pkg::WR_CYC
) (
   input  wire logic REF_CLK,
   input  wire logic RST_B,
   input  wire logic TRANSMIT_ONLY_CLOCK,
   input  wire logic SCL,
   input  wire logic SDA_I,
   output logic      SDA_O,
   output logic      SDA_OE,
   output logic      MODE_BIDIR
);
   typedef struct packed {
      logic                 bidir;
      dmsep_pkg::dmsep_st_e st;
      logic [3:0]           bitc;
      logic [7:0]           sh;
      logic [6:0]           ptr;
      logic                 rw;
      logic                 ack;
      logic                 drv;
      logic                 oe;
      logic [15:0]          vld;
      logic [4:0]           step;
      logic [15:0]          tmr;
      logic                 scl_q;
      logic                 sda_q;
   } dmsep_ref_s;

   typedef struct packed {
      logic [3:0] init;
      logic [3:0] bitn;
      logic [6:0] addr;
      logic [7:0] sh;
      logic       low;
   } dmsep_tx_s;

   dmsep_ref_s r;
   dmsep_ref_s next_r;
   dmsep_tx_s  t;
   dmsep_tx_s  next_t;

   logic       scl_s;
   logic       sda_s;
   logic       wp_s;
   logic       txlow_s;
   logic       sda_t;
   logic       mode_t;
   logic       start;
   logic       stop;
   logic       rise;
   logic       fall;
   logic       buf_we;
   logic [7:0] buf_rd;
   logic [7:0] rd_a;
   logic [7:0] tx_rd;
   logic       mem_we;
   logic [3:0] wr_idx;

   // pins into the system clock; reset at idle levels, so no false fall
   dmsep_sync #(.W(4), .RST_VAL(4'hc)) u_sync_ref (
      .clk   (REF_CLK),
      .rst_b (RST_B),
      .d     ({SCL, SDA_I, TRANSMIT_ONLY_CLOCK, t.low}),
      .q     ({scl_s, sda_s, wp_s, txlow_s})
   );

   // data line and mode flag into the transmit clock domain
   dmsep_sync #(.W(2), .RST_VAL(2'h2)) u_sync_tx (
      .clk   (TRANSMIT_ONLY_CLOCK),
      .rst_b (RST_B),
      .d     ({SDA_I, r.bidir}),
      .q     ({sda_t, mode_t})
   );

   // main array: programmed from the buffer, read by both modes
   dmsep_mem #(.DW(8), .AW(dmsep_pkg::ADDR_W)) u_array (
      .clk_a (REF_CLK),
      .we    (mem_we),
      .wa    ({r.ptr[6:4], wr_idx}),
      .wd    (buf_rd),
      .ra    (r.ptr),
      .rd_a  (rd_a),
      .clk_b (TRANSMIT_ONLY_CLOCK),
      .rb    (t.addr),
      .rd_b  (tx_rd)
   );

   // page buffer, sixteen bytes
   dmsep_mem #(.DW(8), .AW(dmsep_pkg::PAGE_W)) u_page (
      .clk_a (REF_CLK),
      .we    (buf_we),
      .wa    (r.ptr[3:0]),
      .wd    (r.sh),
      .ra    (r.step[3:0]),
      .rd_a  (buf_rd),
      .clk_b (REF_CLK),
      .rb    (4'h0),
      .rd_b  ()
   );

   // bus conditions from the synchronised lines
   assign start = r.scl_q & scl_s & r.sda_q & ~sda_s;
   assign stop  = r.scl_q & scl_s & ~r.sda_q & sda_s;
   assign rise  = ~r.scl_q & scl_s;
   assign fall  = r.scl_q & ~scl_s;

   // buffer walk: step s writes the byte read at step s-1
   assign wr_idx = 4'(r.step - 5'h01);
   assign mem_we = (r.st == dmsep_pkg::PROG) && (r.step != 5'h00) &&
                   (r.step <= dmsep_pkg::STEP_LAST) && r.vld[wr_idx];

   // pins: open drain, low only
   assign SDA_O      = 1'b0;
   assign SDA_OE     = r.oe;
   assign MODE_BIDIR = r.bidir;

   // slave controller next state
   always_comb begin
      next_r       = r;
      buf_we       = 1'b0;
      next_r.scl_q = scl_s;
      next_r.sda_q = sda_s;
      next_r.bidir = r.bidir | (r.scl_q & ~scl_s);
      if (r.st == dmsep_pkg::PROG) begin
         // self-timed cycle, bus and protect level ignored
         next_r.drv = 1'b0;
         if (r.step != dmsep_pkg::STEP_END) begin
            next_r.step = r.step + 5'h01;
         end
         next_r.tmr = r.tmr + 16'h0001;
         if (r.tmr == 16'(WR_CYC - 1)) begin
            next_r.st = dmsep_pkg::IDLE;
         end
      end else if (!r.bidir) begin
         next_r.st = dmsep_pkg::IDLE;
      end else if (start) begin
         next_r.st   = dmsep_pkg::ADDR;
         next_r.bitc = 4'h0;
         next_r.drv  = 1'b0;
      end else if (stop) begin
         next_r.drv = 1'b0;
         next_r.st  = dmsep_pkg::IDLE;
         if ((r.st == dmsep_pkg::WDATA || r.st == dmsep_pkg::WDATA_ACK) &&
             (|r.vld) && wp_s) begin
            next_r.st   = dmsep_pkg::PROG;
            next_r.step = 5'h00;
            next_r.tmr  = 16'h0000;
         end
      end else if (rise) begin
         case (r.st)
            dmsep_pkg::ADDR, dmsep_pkg::WORD, dmsep_pkg::WDATA: begin
               next_r.sh   = {r.sh[6:0], sda_s};
               next_r.bitc = r.bitc + 4'h1;
            end
            dmsep_pkg::RDATA: begin
               next_r.bitc = r.bitc + 4'h1;
            end
            dmsep_pkg::RDATA_ACK: begin
               next_r.ack = ~sda_s;
            end
            default: begin
               next_r.bitc = r.bitc;
            end
         endcase
      end else if (fall) begin
         case (r.st)
            dmsep_pkg::ADDR: begin
               if (r.bitc == dmsep_pkg::SLOT_ACK) begin
                  if (r.sh[7:4] == DEV_CODE) begin
                     next_r.drv = 1'b1;
                     next_r.rw  = r.sh[0];
                     next_r.st  = dmsep_pkg::ADDR_ACK;
                  end else begin
                     next_r.st = dmsep_pkg::IDLE;
                  end
               end
            end
            dmsep_pkg::WORD: begin
               if (r.bitc == dmsep_pkg::SLOT_ACK) begin
                  next_r.ptr = r.sh[6:0];
                  next_r.vld = 16'h0000;
                  next_r.drv = 1'b1;
                  next_r.st  = dmsep_pkg::WORD_ACK;
               end
            end
            dmsep_pkg::WDATA: begin
               if (r.bitc == dmsep_pkg::SLOT_ACK) begin
                  buf_we               = 1'b1;
                  next_r.vld[r.ptr[3:0]] = 1'b1;
                  next_r.ptr[3:0]      = r.ptr[3:0] + 4'h1;
                  next_r.drv           = 1'b1;
                  next_r.st            = dmsep_pkg::WDATA_ACK;
               end
            end
            dmsep_pkg::ADDR_ACK: begin
               next_r.drv  = 1'b0;
               next_r.bitc = 4'h0;
               if (r.rw) begin
                  next_r.sh  = rd_a;
                  next_r.ptr = r.ptr + 7'h01;
                  next_r.drv = ~rd_a[7];
                  next_r.st  = dmsep_pkg::RDATA;
               end else begin
                  next_r.st = dmsep_pkg::WORD;
               end
            end
            dmsep_pkg::WORD_ACK, dmsep_pkg::WDATA_ACK: begin
               next_r.drv  = 1'b0;
               next_r.bitc = 4'h0;
               next_r.st   = dmsep_pkg::WDATA;
            end
            dmsep_pkg::RDATA: begin
               if (r.bitc == dmsep_pkg::SLOT_ACK) begin
                  next_r.drv = 1'b0;
                  next_r.st  = dmsep_pkg::RDATA_ACK;
               end else begin
                  next_r.sh  = {r.sh[6:0], 1'b0};
                  next_r.drv = ~r.sh[6];
               end
            end
            dmsep_pkg::RDATA_ACK: begin
               if (r.ack) begin
                  next_r.sh   = rd_a;
                  next_r.ptr  = r.ptr + 7'h01;
                  next_r.drv  = ~rd_a[7];
                  next_r.bitc = 4'h0;
                  next_r.st   = dmsep_pkg::RDATA;
               end else begin
                  next_r.st = dmsep_pkg::IDLE;
               end
            end
            default: begin
               next_r.drv = 1'b0;
            end
         endcase
      end
      // pin enable follows the active mode
      next_r.oe = next_r.bidir ? next_r.drv : txlow_s;
   end

   // slave controller state register
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         r       <= '0;
         r.st    <= dmsep_pkg::IDLE;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // transmit-only sequencer next state
   always_comb begin
      next_t = t;
      if (mode_t) begin
         next_t.low = 1'b0;
      end else if (t.init != dmsep_pkg::INIT_DONE) begin
         next_t.init = t.init + 4'h1;
         next_t.low  = 1'b0;
         if (t.init == dmsep_pkg::INIT_PICK) begin
            next_t.addr = sda_t ? dmsep_pkg::TX_START_HI
                                : dmsep_pkg::TX_START_LO;
         end
         if (t.init == dmsep_pkg::INIT_LAST) begin
            next_t.bitn = dmsep_pkg::SLOT_ACK;
         end
      end else if (t.bitn == dmsep_pkg::SLOT_ACK) begin
         next_t.bitn = 4'h0;
         next_t.sh   = tx_rd;
         next_t.low  = ~tx_rd[7];
      end else begin
         next_t.bitn = t.bitn + 4'h1;
         next_t.sh   = {t.sh[6:0], 1'b0};
         next_t.low  = (t.bitn == 4'h7) ? 1'b0 : ~t.sh[6];
         if (t.bitn == dmsep_pkg::SLOT_NEXT) begin
            next_t.addr = t.addr + 7'h01;
         end
      end
   end

   // transmit-only sequencer state register
   always_ff @(posedge TRANSMIT_ONLY_CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         t <= '0;
      end else begin
         t <= next_t;
      end
   end

   // checks on the system clock side
   mode_stays_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_B) r.bidir |=> r.bidir)
      else $error("bidirectional mode was left");
   mode_switch_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      (!r.bidir && r.scl_q && !scl_s) |=> r.bidir)
      else $error("bus clock fall did not switch mode");
   addr_ack_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      (r.bidir && r.st == dmsep_pkg::ADDR && fall &&
       r.bitc == 4'h8 && r.sh[7:4] == DEV_CODE)
      |=> (r.drv && r.st == dmsep_pkg::ADDR_ACK) ##1 r.oe)
      else $error("matching address not acknowledged");
   prog_quiet_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      (r.st == dmsep_pkg::PROG) |=> (r.st != dmsep_pkg::PROG) || !r.oe)
      else $error("data line driven during write cycle");
   prog_len_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      (r.st == dmsep_pkg::PROG && r.tmr == 16'(WR_CYC - 1))
      |=> r.st == dmsep_pkg::IDLE)
      else $error("write cycle overran");
   protect_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      (r.bidir && r.st != dmsep_pkg::PROG && stop && !wp_s)
      |=> r.st != dmsep_pkg::PROG)
      else $error("programming started while protected");
   page_step_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      (r.bidir && r.st == dmsep_pkg::WDATA && fall && r.bitc == 4'h8)
      |=> (r.ptr[6:4] == $past(r.ptr[6:4]) &&
           r.ptr[3:0] == $past(r.ptr[3:0]) + 4'h1))
      else $error("page address stepped wrongly");
   read_wrap_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_B)
      (r.bidir && fall && r.ptr == 7'h7f && ((r.st == dmsep_pkg::RDATA_ACK &&
       r.ack) || (r.st == dmsep_pkg::ADDR_ACK && r.rw))) |=> r.ptr == 7'h00)
      else $error("address counter did not wrap");

   // checks on the transmit clock side
   tx_init_a: assert property (
      @(posedge TRANSMIT_ONLY_CLOCK) disable iff (!RST_B)
      (t.init != dmsep_pkg::INIT_DONE) |-> !t.low)
      else $error("data driven before initialization ended");
   tx_slot_a: assert property (
      @(posedge TRANSMIT_ONLY_CLOCK) disable iff (!RST_B)
      (t.init == dmsep_pkg::INIT_DONE && t.bitn == 4'h8) |-> !t.low)
      else $error("ninth slot not released");
   tx_wrap_a: assert property (
      @(posedge TRANSMIT_ONLY_CLOCK) disable iff (!RST_B)
      (!mode_t && t.init == dmsep_pkg::INIT_DONE && t.bitn == 4'h6 &&
       t.addr == 7'h7f) |=> t.addr == 7'h00)
      else $error("stream did not wrap to zero");
endmodule // dmsep_port

// ---- tb/dmsep_host.sv ----
/*
 two-wire bus master and transmit clock source facing the memory port.
 assumes the bench resolves the data line from both open-drain drivers.
*/
`timescale 1ns/1ps
module dmsep_host (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_o,
   output logic      tx_clk
);
   // idle bus: clock held high keeps the port in transmit-only mode
   initial begin
      scl = 1'b1;
      sda_o = 1'b1;
      tx_clk = 1'b0;
   end

   // wait a number of system clock edges
   task automatic q(input int n);
      repeat (n) @(posedge clk);
   endtask

   // start or repeated start: data falls while clock high
   task automatic start();
      sda_o <= 1'b1;
      q(5);
      scl <= 1'b1;
      q(5);
      sda_o <= 1'b0;
      q(5);
      scl <= 1'b0;
      q(5);
   endtask

   // stop: data rises while clock high, clock left high
   task automatic stop();
      sda_o <= 1'b0;
      q(5);
      scl <= 1'b1;
      q(5);
      sda_o <= 1'b1;
      q(5);
   endtask

   // one bit slot, data sampled in the middle of the high phase
   task automatic bit_cyc(input logic b, output logic s);
      sda_o <= b;
      q(5);
      scl <= 1'b1;
      q(5);
      s = sda;
      q(5);
      scl <= 1'b0;
      q(5);
   endtask

   // send a byte msb first, then read the acknowledge slot
   task automatic wbyte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(d[i], ack);
      end
      bit_cyc(1'b1, ack);
   endtask

   // read a byte, then acknowledge it or not
   task automatic rbyte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b1, s);
         d[i] = s;
      end
      bit_cyc(~mack, s);
   endtask

   // one transmit clock pulse, off phase, then let the output settle
   task automatic txp();
      #7 tx_clk = 1'b1;
      #16 tx_clk = 1'b0;
      q(6);
   endtask
endmodule // dmsep_host

// ---- tb/tb.sv ----
/*
 self-checking bench of the dual-mode memory port: transmit-only start,
 mode switch, page write, polling, protection, reads, restart stream.
 assumes the port and package from rtl and the host model from tb.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
   err_count++; $display("mismatch at %0t: got %h want %h", $time, \
   a, e); end end
module tb;
   localparam int unsigned WR  = 400;
   localparam logic [3:0]  DEV = dmsep_pkg::DEV_CODE_DEF;
   logic ref_clk, rst_b, scl, m_sda, tx_clk, sda_o, sda_oe, mode_bidir;
   int   err_count, samples_checked;
   wire  sda = m_sda & (sda_oe ? sda_o : 1'b1);

   dmsep_port #(.DEV_CODE(DEV), .WR_CYC(WR)) dut (
      .REF_CLK(ref_clk), .RST_B(rst_b), .TRANSMIT_ONLY_CLOCK(tx_clk),
      .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
      .MODE_BIDIR(mode_bidir));
   dmsep_host host (.clk(ref_clk), .sda(sda), .scl(scl), .sda_o(m_sda),
      .tx_clk(tx_clk));

   // send a byte and judge the acknowledge slot
   task automatic send(input logic [7:0] d, input logic exp);
      logic a;
      host.wbyte(d, a);
      `CHK(a, exp)
   endtask

   // read a byte and judge it
   task automatic rd(input logic mack, input logic [7:0] exp);
      logic [7:0] d;
      host.rbyte(mack, d);
      `CHK(d, exp)
   endtask

   // initialization pulses leave the line free, then a clock fall
   task automatic t_init();
      for (int i = 0; i < 9; i++) begin
         host.txp();
         `CHK(sda_oe, 1'b0)
      end
      `CHK(mode_bidir, 1'b0)
      host.scl <= 1'b0;
      host.q(5);
      host.scl <= 1'b1;
      host.q(10);
      `CHK(mode_bidir, 1'b1)
   endtask

   // seventeen bytes into page 7, busy poll, then two-byte write at 0
   task automatic t_page();
      host.tx_clk <= 1'b1;
      host.start();
      send({DEV, 4'ha}, 1'b0);
      send(8'h70, 1'b0);
      for (int i = 0; i < 17; i++) begin
         send(8'h40 + 8'(i), 1'b0);
      end
      host.stop();
      host.start();
      send({DEV, 4'h0}, 1'b1);
      host.stop();
      host.q(WR);
      host.start();
      send({DEV, 4'h4}, 1'b0);
      send(8'h00, 1'b0);
      send(8'ha5, 1'b0);
      send(8'h5a, 1'b0);
      host.stop();
      host.tx_clk <= 1'b0;
      host.q(WR);
   endtask

   // pulses are ignored in slave mode; write with protect low
   task automatic t_prot();
      for (int i = 0; i < 3; i++) begin
         host.txp();
      end
      `CHK(mode_bidir, 1'b1)
      host.start();
      send({DEV, 4'ha}, 1'b0);
      send(8'h00, 1'b0);
      send(8'h3c, 1'b0);
      host.stop();
      host.q(WR);
   endtask

   // selective, sequential and immediate reads, foreign code
   task automatic t_read();
      host.start();
      send({DEV, 4'ha}, 1'b0);
      send(8'h7f, 1'b0);
      host.start();
      send({DEV, 4'hb}, 1'b0);
      rd(1'b1, 8'h4f);
      rd(1'b0, 8'ha5);
      `CHK(sda, 1'b1)
      host.stop();
      host.start();
      send({DEV, 4'ha}, 1'b0);
      send(8'h70, 1'b0);
      host.start();
      send({DEV, 4'hb}, 1'b0);
      rd(1'b1, 8'h50);
      rd(1'b0, 8'h41);
      host.stop();
      host.start();
      send({DEV, 4'hb}, 1'b0);
      rd(1'b0, 8'h42);
      host.stop();
      host.start();
      send({~DEV, 4'ha}, 1'b1);
      host.stop();
   endtask

   // power-up again with the line at lvl: stream from 7FH or 00H
   task automatic t_stream(input logic lvl, input logic [7:0] b0,
                           input logic [7:0] b1);
      logic [7:0] ex [2];
      ex = '{b0, b1};
      rst_b <= 1'b0;
      host.sda_o <= lvl;
      host.q(6);
      rst_b <= 1'b1;
      host.q(3);
      `CHK(mode_bidir, 1'b0)
      for (int i = 0; i < 9; i++) begin
         host.txp();
      end
      host.sda_o <= 1'b1;
      for (int b = 0; b < 2; b++) begin
         for (int i = 7; i >= 0; i--) begin
            host.txp();
            `CHK(sda_oe, ~ex[b][i])
         end
         host.txp();
         `CHK(sda_oe, 1'b0)
      end
   endtask

   // print counts and the verdict, then stop
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // system clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // main sequence
   initial begin
      rst_b = 1'b0;
      err_count = 0;
      samples_checked = 0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      host.q(3);
      t_init();
      t_page();
      t_prot();
      t_read();
      t_stream(1'b1, 8'h4f, 8'ha5);
      t_stream(1'b0, 8'ha5, 8'h5a);
      test_done();
   end

   // watchdog: the run needs about 0.9 ms, allow over three times that
   initial begin
      #4_000_000;
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      test_done();
   end
endmodule // tb
